//--- design/pair_select.sv
`timescale 1ns/1ps
`default_nettype none
module pair_select #(
  parameter int DATA_W = 8,
  parameter int POS_W = 2
) (
  input wire logic [DATA_W-1:0] data,
  input wire logic [POS_W-1:0] pos,
  output logic [1:0] pair
);
  // bit pair 2*pos .. 2*pos+1 of the byte
  assign pair = data[{pos, 1'b0} +: 2];
endmodule : pair_select
`default_nettype wire

//--- design/planar_bit_group_position_regs.sv
// Behaviour
// - planes 0/1 take data bit pair chosen by lower position value
// - planes 2/3 take data bit pair chosen by upper position value
// - chosen pair applies to planar register writes and memory data
// - rotate, read select, mode, bit mask ignore position values
// - planar reads return plane 0 on bit 0, plane 1 on bit 1
// - planar reads return plane 2 on bit 2, plane 3 on bit 3
// - four bits writable at a time, read on bits 0-3, upper bits not stored and read as 0
// - reset loads lower position 0 and upper position 1
// - upper written at own port, both read via sequencer index 1/2
// - four-bit index selects register reached by data port
// - positions and planar registers guarded by write guard bit
// - write mode 0, fill enabled: plane gets fill bit on all bits
// - write mode 0, fill disabled: plane gets processor data byte
// - while guard active, writes to guarded registers are blocked
// - compare read drives 1 where every plane with its ignore bit set matches
`timescale 1ns/1ps
`default_nettype none
module planar_bit_group_position_regs (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [plane_regs_pkg::ADDR_W-1:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [plane_regs_pkg::DATA_W-1:0] io_wdata,
  output logic [plane_regs_pkg::DATA_W-1:0] io_rdata_r,
  output logic io_rvalid_r,
  input wire logic write_guard_on,
  input wire logic mem_wr,
  input wire logic [plane_regs_pkg::DATA_W-1:0] mem_wdata_cpu,
  output logic [plane_regs_pkg::PLANES*plane_regs_pkg::DATA_W-1:0] mem_wdata_r,
  output logic mem_we_r,
  input wire logic mem_rd,
  input wire logic [plane_regs_pkg::PLANES*plane_regs_pkg::DATA_W-1:0] mem_rdata_planes,
  output logic [plane_regs_pkg::DATA_W-1:0] mem_rdata_r,
  output logic mem_rvalid_r
);
  import plane_regs_pkg::*;

  // state
  logic [POS_W-1:0] lower_pos_r;
  logic [POS_W-1:0] upper_pos_r;
  logic [IDX_W-1:0] index_r;
  logic [SEQ_IDX_W-1:0] seq_index_r;
  logic [PLANES-1:0] fill_value_r;
  logic [PLANES-1:0] fill_enable_r;
  logic [PLANES-1:0] match_value_r;
  logic [PLANES-1:0] ignore_r;
  logic [DATA_W-1:0] rotate_r;
  logic [DATA_W-1:0] read_sel_r;
  logic [DATA_W-1:0] mode_r;
  logic [DATA_W-1:0] misc_r;
  logic [DATA_W-1:0] bit_mask_r;
  logic [PLANES*DATA_W-1:0] latch_r;
  // decoded strobes
  logic wr_lower_pos;
  logic wr_upper_pos;
  logic wr_index;
  logic wr_seq_index;
  logic wr_data;
  logic wr_guarded_ok;
  // steered io pairs and next planar values
  logic [PAIR_W-1:0] io_pair_lo;
  logic [PAIR_W-1:0] io_pair_hi;
  logic [PLANES-1:0] planar_nxt;
  logic [DATA_W-1:0] io_rdata_nxt;
  // memory side
  logic [PAIR_W-1:0] mem_pair_lo;
  logic [PAIR_W-1:0] mem_pair_hi;
  logic [PLANES-1:0] pin_bits;
  logic [DATA_W-1:0] rot_data;
  logic [ROT_W-1:0] rot_cnt;
  write_mode_t wmode;
  alu_op_t alu_op;
  logic [PLANES*DATA_W-1:0] plane_wdata;
  logic [DATA_W-1:0] cmp_result;
  logic [DATA_W-1:0] mem_rdata_nxt;
  // port decode
  assign wr_lower_pos = io_wr && (io_addr == PORT_LOWER_POS);
  assign wr_upper_pos = io_wr && (io_addr == PORT_UPPER_POS);
  assign wr_index = io_wr && (io_addr == PORT_GR_INDEX);
  assign wr_seq_index = io_wr && (io_addr == PORT_SEQ_INDEX);
  assign wr_data = io_wr && (io_addr == PORT_GR_DATA);
  assign wr_guarded_ok = !write_guard_on;
  pair_select #(.DATA_W(DATA_W), .POS_W(POS_W)) u_io_lo (
    .data(io_wdata),
    .pos(lower_pos_r),
    .pair(io_pair_lo)
  );
  pair_select #(.DATA_W(DATA_W), .POS_W(POS_W)) u_io_hi (
    .data(io_wdata),
    .pos(upper_pos_r),
    .pair(io_pair_hi)
  );
  // each pair lands on its own two planes
  assign planar_nxt = {io_pair_hi, io_pair_lo};
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lower_pos_r <= LOWER_POS_RESET;
      upper_pos_r <= UPPER_POS_RESET;
    end else if (ce) begin
      if (wr_lower_pos && wr_guarded_ok) begin
        lower_pos_r <= io_wdata[POS_W-1:0];
      end
      if (wr_upper_pos && wr_guarded_ok) begin
        upper_pos_r <= io_wdata[POS_W-1:0];
      end
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      index_r <= IDX_RESET;
      seq_index_r <= SEQ_IDX_RESET;
    end else if (ce) begin
      if (wr_index) begin
        index_r <= io_wdata[IDX_W-1:0];
      end
      if (wr_seq_index) begin
        seq_index_r <= io_wdata;
      end
    end
  end
  // planar registers take only four steered bits
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fill_value_r <= PLANAR_RESET;
      fill_enable_r <= PLANAR_RESET;
      match_value_r <= PLANAR_RESET;
      ignore_r <= PLANAR_RESET;
    end else if (ce && wr_data && wr_guarded_ok) begin
      case (index_r)
        IDX_FILL_VALUE: fill_value_r <= planar_nxt;
        IDX_FILL_ENABLE: fill_enable_r <= planar_nxt;
        IDX_MATCH_VALUE: match_value_r <= planar_nxt;
        IDX_IGNORE: ignore_r <= planar_nxt;
        default: ;
      endcase
    end
  end
  // non-planar registers take the byte as written
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rotate_r <= REG_RESET;
      read_sel_r <= REG_RESET;
      mode_r <= REG_RESET;
      misc_r <= REG_RESET;
      bit_mask_r <= MASK_ALL;
    end else if (ce && wr_data && wr_guarded_ok) begin
      case (index_r)
        IDX_ROTATE: rotate_r <= io_wdata;
        IDX_READ_SEL: read_sel_r <= io_wdata;
        IDX_MODE: mode_r <= io_wdata;
        IDX_MISC: misc_r <= io_wdata;
        IDX_BIT_MASK: bit_mask_r <= io_wdata;
        default: ;
      endcase
    end
  end
  // io read mux
  always_comb begin
    io_rdata_nxt = REG_RESET;
    case (io_addr)
      PORT_GR_INDEX: io_rdata_nxt = {{(DATA_W-IDX_W){1'b0}}, index_r};
      PORT_SEQ_INDEX: io_rdata_nxt = seq_index_r;
      PORT_SEQ_DATA: begin
        if (seq_index_r == SEQ_IDX_LOWER_POS) begin
          io_rdata_nxt = {{(DATA_W-POS_W){1'b0}}, lower_pos_r};
        end else if (seq_index_r == SEQ_IDX_UPPER_POS) begin
          io_rdata_nxt = {{(DATA_W-POS_W){1'b0}}, upper_pos_r};
        end
      end
      PORT_GR_DATA: begin
        // planar bits read at fixed plane order
        case (index_r)
          IDX_FILL_VALUE: io_rdata_nxt = {{(DATA_W-PLANES){1'b0}}, fill_value_r};
          IDX_FILL_ENABLE: io_rdata_nxt = {{(DATA_W-PLANES){1'b0}}, fill_enable_r};
          IDX_MATCH_VALUE: io_rdata_nxt = {{(DATA_W-PLANES){1'b0}}, match_value_r};
          IDX_IGNORE: io_rdata_nxt = {{(DATA_W-PLANES){1'b0}}, ignore_r};
          IDX_ROTATE: io_rdata_nxt = rotate_r;
          IDX_READ_SEL: io_rdata_nxt = read_sel_r;
          IDX_MODE: io_rdata_nxt = mode_r;
          IDX_MISC: io_rdata_nxt = misc_r;
          IDX_BIT_MASK: io_rdata_nxt = bit_mask_r;
          default: io_rdata_nxt = REG_RESET;
        endcase
      end
      default: io_rdata_nxt = REG_RESET;
    endcase
  end
  // io read register, one cycle after strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      io_rdata_r <= REG_RESET;
      io_rvalid_r <= 1'b0;
    end else if (ce) begin
      io_rvalid_r <= io_rd;
      if (io_rd) begin
        io_rdata_r <= io_rdata_nxt;
      end
    end
  end
  // mode fields
  assign wmode = write_mode_t'(mode_r[WMODE_LSB +: 2]);
  assign alu_op = alu_op_t'(rotate_r[FUNC_LSB +: 2]);
  assign rot_cnt = rotate_r[ROT_CNT_LSB +: ROT_W];
  // right circular rotate of cpu data
  assign rot_data = DATA_W'({mem_wdata_cpu, mem_wdata_cpu} >> rot_cnt);

  // memory data pair steering, lower controller
  pair_select #(.DATA_W(DATA_W), .POS_W(POS_W)) u_mem_lo (
    .data(mem_wdata_cpu),
    .pos(lower_pos_r),
    .pair(mem_pair_lo)
  );

  // memory data pair steering, upper controller
  pair_select #(.DATA_W(DATA_W), .POS_W(POS_W)) u_mem_hi (
    .data(mem_wdata_cpu),
    .pos(upper_pos_r),
    .pair(mem_pair_hi)
  );
  assign pin_bits = {mem_pair_hi, mem_pair_lo};
  genvar p;
  generate
    for (p = 0; p < PLANES; p++) begin : g_plane
      plane_write_unit u_pwu (
        .wmode(wmode),
        .op(alu_op),
        .fill_bit(fill_value_r[p]),
        .fill_en(fill_enable_r[p]),
        .pin_bit(pin_bits[p]),
        .rot_data(rot_data),
        .latch(latch_r[p*DATA_W +: DATA_W]),
        .bit_mask(bit_mask_r),
        .wdata(plane_wdata[p*DATA_W +: DATA_W])
      );
    end
  endgenerate

  // memory write register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mem_wdata_r <= '0;
      mem_we_r <= 1'b0;
    end else if (ce) begin
      mem_we_r <= mem_wr;
      if (mem_wr) begin
        mem_wdata_r <= plane_wdata;
      end
    end
  end

  // colour compare, planes with ignore bit clear always match
  always_comb begin
    cmp_result = MASK_ALL;
    for (int q = 0; q < PLANES; q++) begin
      cmp_result = cmp_result & ~({DATA_W{ignore_r[q]}}
        & (mem_rdata_planes[q*DATA_W +: DATA_W] ^ {DATA_W{match_value_r[q]}}));
    end
  end

  // read mode select
  always_comb begin
    mem_rdata_nxt = REG_RESET;
    if (mode_r[READ_MODE_BIT]) begin
      mem_rdata_nxt = cmp_result;
    end else if (!read_sel_r[READ_SEL_NONE_BIT]) begin
      mem_rdata_nxt = mem_rdata_planes[read_sel_r[1:0]*DATA_W +: DATA_W];
    end
  end

  // memory read register and latches
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mem_rdata_r <= REG_RESET;
      mem_rvalid_r <= 1'b0;
      latch_r <= '0;
    end else if (ce) begin
      mem_rvalid_r <= mem_rd;
      if (mem_rd) begin
        mem_rdata_r <= mem_rdata_nxt;
        latch_r <= mem_rdata_planes;
      end
    end
  end

  // checks
  a_reset_positions: assert property (
    @(posedge sys_clk) $fell(rst) |-> lower_pos_r == LOWER_POS_RESET
      && upper_pos_r == UPPER_POS_RESET)
    else $error("positions not at reset values");
  a_guard_blocks_pos: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce && write_guard_on && (wr_lower_pos || wr_upper_pos)
      |=> $stable(lower_pos_r) && $stable(upper_pos_r))
    else $error("guarded position write took effect");
  a_upper_pos_port: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce && !write_guard_on && wr_upper_pos
      |=> upper_pos_r == $past(io_wdata[POS_W-1:0]))
    else $error("upper position write lost");
  a_guard_planar: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce && write_guard_on && wr_data
      |=> $stable(fill_value_r) && $stable(bit_mask_r) && $stable(mode_r))
    else $error("guarded register written");
  a_pair_steer: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce && !write_guard_on && wr_data && index_r == IDX_FILL_VALUE
      |=> fill_value_r[1:0] == $past(io_wdata >> {lower_pos_r, 1'b0}) % 4
      && fill_value_r[3:2] == $past(io_wdata >> {upper_pos_r, 1'b0}) % 4)
    else $error("planar bit pair steered wrong");
  a_nonplanar_mask: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce && !write_guard_on && wr_data && index_r == IDX_BIT_MASK
      |=> bit_mask_r == $past(io_wdata))
    else $error("non-planar register steered");
  a_planar_readback: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce && io_rd && io_addr == PORT_GR_DATA && index_r == IDX_FILL_ENABLE
      |=> io_rvalid_r && io_rdata_r == {4'h0, $past(fill_enable_r)})
    else $error("planar readback order wrong");
  a_pos_readback: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce && io_rd && io_addr == PORT_SEQ_DATA && seq_index_r == SEQ_IDX_LOWER_POS
      |=> io_rdata_r == {6'h00, $past(lower_pos_r)})
    else $error("position readback wrong");
  a_index_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce && wr_index |=> index_r == $past(io_wdata[IDX_W-1:0]))
    else $error("index not stored");
  a_fill_mode0: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce && mem_wr && wmode == WM_DIRECT && alu_op == OP_PASS
      && bit_mask_r == MASK_ALL && fill_enable_r[0]
      |=> mem_we_r && mem_wdata_r[7:0] == {8{$past(fill_value_r[0])}})
    else $error("fill value not written");
  a_cpu_mode0: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce && mem_wr && wmode == WM_DIRECT && alu_op == OP_PASS && rot_cnt == 0
      && bit_mask_r == MASK_ALL && !fill_enable_r[3]
      |=> mem_wdata_r[31:24] == $past(mem_wdata_cpu))
    else $error("cpu data not written");
  a_compare_read: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce && mem_rd && mode_r[READ_MODE_BIT] && ignore_r == 4'hF
      |=> mem_rvalid_r && mem_rdata_r == ~($past(mem_rdata_planes[7:0] ^ {8{match_value_r[0]}})
      | $past(mem_rdata_planes[15:8] ^ {8{match_value_r[1]}})
      | $past(mem_rdata_planes[23:16] ^ {8{match_value_r[2]}})
      | $past(mem_rdata_planes[31:24] ^ {8{match_value_r[3]}})))
    else $error("compare read mismatch");
endmodule : planar_bit_group_position_regs
`default_nettype wire

//--- design/plane_regs_pkg.sv
package plane_regs_pkg;
  // geometry
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int PLANES = 4;
  localparam int POS_W = 2;
  localparam int PAIR_W = 2;
  localparam int IDX_W = 4;
  localparam int SEQ_IDX_W = 8;
  localparam int ROT_W = 3;
  localparam int SEL_W = 3;
  // i/o port addresses
  localparam logic [ADDR_W-1:0] PORT_SEQ_INDEX = 10'h3C4;
  localparam logic [ADDR_W-1:0] PORT_SEQ_DATA = 10'h3C5;
  localparam logic [ADDR_W-1:0] PORT_UPPER_POS = 10'h3CA;
  localparam logic [ADDR_W-1:0] PORT_LOWER_POS = 10'h3CC;
  localparam logic [ADDR_W-1:0] PORT_GR_INDEX = 10'h3CE;
  localparam logic [ADDR_W-1:0] PORT_GR_DATA = 10'h3CF;
  // sequencer readback indexes
  localparam logic [SEQ_IDX_W-1:0] SEQ_IDX_LOWER_POS = 8'h01;
  localparam logic [SEQ_IDX_W-1:0] SEQ_IDX_UPPER_POS = 8'h02;
  // graphics register indexes
  localparam logic [IDX_W-1:0] IDX_FILL_VALUE = 4'h0;
  localparam logic [IDX_W-1:0] IDX_FILL_ENABLE = 4'h1;
  localparam logic [IDX_W-1:0] IDX_MATCH_VALUE = 4'h2;
  localparam logic [IDX_W-1:0] IDX_ROTATE = 4'h3;
  localparam logic [IDX_W-1:0] IDX_READ_SEL = 4'h4;
  localparam logic [IDX_W-1:0] IDX_MODE = 4'h5;
  localparam logic [IDX_W-1:0] IDX_MISC = 4'h6;
  localparam logic [IDX_W-1:0] IDX_IGNORE = 4'h7;
  localparam logic [IDX_W-1:0] IDX_BIT_MASK = 4'h8;
  // reset values
  localparam logic [POS_W-1:0] LOWER_POS_RESET = 2'h0;
  localparam logic [POS_W-1:0] UPPER_POS_RESET = 2'h1;
  localparam logic [PLANES-1:0] PLANAR_RESET = 4'h0;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] MASK_ALL = 8'hFF;
  localparam logic [DATA_W-1:0] MASK_NONE = 8'h00;
  localparam logic [IDX_W-1:0] IDX_RESET = 4'h0;
  localparam logic [SEQ_IDX_W-1:0] SEQ_IDX_RESET = 8'h00;
  // field positions
  localparam int ROT_CNT_LSB = 0;
  localparam int FUNC_LSB = 3;
  localparam int WMODE_LSB = 0;
  localparam int READ_MODE_BIT = 3;
  localparam int READ_SEL_NONE_BIT = 2;
  localparam int PAIR_HI = 1;
  localparam int PAIR_LO = 0;
  localparam int UPPER_LSB = 2;
  typedef enum logic [1:0] {
    WM_DIRECT = 2'b00, WM_LATCH = 2'b01, WM_FILL = 2'b10, WM_MASKED = 2'b11
  } write_mode_t;
  typedef enum logic [1:0] {
    OP_PASS = 2'b00, OP_AND = 2'b01, OP_OR = 2'b10, OP_XOR = 2'b11
  } alu_op_t;
endpackage : plane_regs_pkg

//--- design/plane_write_unit.sv
`timescale 1ns/1ps
`default_nettype none
module plane_write_unit
  import plane_regs_pkg::*;
(
  input wire write_mode_t wmode,
  input wire alu_op_t op,
  input wire logic fill_bit,
  input wire logic fill_en,
  input wire logic pin_bit,
  input wire logic [DATA_W-1:0] rot_data,
  input wire logic [DATA_W-1:0] latch,
  input wire logic [DATA_W-1:0] bit_mask,
  output logic [DATA_W-1:0] wdata
);
  logic [DATA_W-1:0] src;
  logic [DATA_W-1:0] res;
  logic [DATA_W-1:0] eff_mask;
  // source byte per write mode
  always_comb begin
    case (wmode)
      WM_DIRECT: src = fill_en ? {DATA_W{fill_bit}} : rot_data;
      WM_LATCH: src = latch;
      WM_FILL: src = {DATA_W{pin_bit}};
      WM_MASKED: src = {DATA_W{fill_bit}};
      default: src = rot_data;
    endcase
  end
  // logic op against latch, then bit mask merge
  always_comb begin
    case (op)
      OP_PASS: res = src;
      OP_AND: res = src & latch;
      OP_OR: res = src | latch;
      OP_XOR: res = src ^ latch;
      default: res = src;
    endcase
    case (wmode)
      WM_LATCH: eff_mask = MASK_NONE;
      WM_MASKED: eff_mask = bit_mask & rot_data;
      default: eff_mask = bit_mask;
    endcase
    wdata = (res & eff_mask) | (latch & ~eff_mask);
  end
endmodule : plane_write_unit
`default_nettype wire

//--- verif/host_io_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_io_model
  import plane_regs_pkg::*;
(
  input wire logic sys_clk,
  output logic [ADDR_W-1:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [DATA_W-1:0] io_wdata,
  input wire logic [DATA_W-1:0] io_rdata_r,
  input wire logic io_rvalid_r
);
  import plane_regs_pkg::*;
  // bus idle at time zero
  initial begin
    io_addr = PORT_GR_INDEX;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // one-cycle write strobe, changed at the falling edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge sys_clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge sys_clk);
    io_wr = 1'b0;
    io_wdata = ~d; // released data stops showing the last value
  endtask : wr
  // one-cycle read strobe, then a bounded wait for the valid pulse
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic ok);
    int n;
    @(negedge sys_clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge sys_clk);
    io_rd = 1'b0;
    ok = 1'b0;
    d = 8'h00;
    for (n = 0; n < 4 && !ok; n++) begin
      if (io_rvalid_r === 1'b1) begin
        ok = 1'b1;
        d = io_rdata_r;
      end else begin
        @(negedge sys_clk);
      end
    end
  endtask : rd
  // restore order: defaults, registers, then saved positions
  // saved positions are kept distinct by the caller
  task automatic restore(input logic [1:0] lo, input logic [1:0] up, input logic [DATA_W-1:0] regs [0:3]);
    int i;
    wr(PORT_LOWER_POS, {6'h00, LOWER_POS_RESET});
    wr(PORT_UPPER_POS, {6'h00, UPPER_POS_RESET});
    for (i = 0; i < 4; i++) begin
      wr(PORT_GR_INDEX, 8'(i));
      wr(PORT_GR_DATA, regs[i]);
    end
    wr(PORT_LOWER_POS, {6'h00, lo});
    wr(PORT_UPPER_POS, {6'h00, up});
  endtask : restore
endmodule : host_io_model
`default_nettype wire

//--- verif/planar_bit_group_position_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module planar_bit_group_position_regs_test;
  import plane_regs_pkg::*;
  typedef struct packed {
    logic [1:0] lo;
    logic [1:0] up;
    logic [3:0] idx;
    logic [7:0] d;
    logic [7:0] exp;
  } row_t;
  // rows keep the two positions distinct
  localparam row_t ROWS [4] = '{'{2'h0, 2'h1, 4'h0, 8'h0E, 8'h0E}, '{2'h2, 2'h3, 4'h1, 8'hB4, 8'h0B},
                                '{2'h3, 2'h0, 4'h2, 8'h9C, 8'h02}, '{2'h1, 2'h2, 4'h7, 8'h64, 8'h09}};
  logic sys_clk, rst, ce, io_wr, io_rd, io_rvalid_r, write_guard_on;
  logic mem_wr, mem_we_r, mem_rd, mem_rvalid_r;
  logic [ADDR_W-1:0] io_addr;
  logic [DATA_W-1:0] io_wdata, io_rdata_r, mem_wdata_cpu, mem_rdata_r, saved [0:3];
  logic [PLANES*DATA_W-1:0] mem_wdata_r, mem_rdata_planes;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  planar_bit_group_position_regs u_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_r(io_rdata_r), .io_rvalid_r(io_rvalid_r),
    .write_guard_on(write_guard_on), .mem_wr(mem_wr), .mem_wdata_cpu(mem_wdata_cpu),
    .mem_wdata_r(mem_wdata_r), .mem_we_r(mem_we_r), .mem_rd(mem_rd), .mem_rdata_planes(mem_rdata_planes),
    .mem_rdata_r(mem_rdata_r), .mem_rvalid_r(mem_rvalid_r));
  host_io_model u_host (.sys_clk(sys_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata_r(io_rdata_r), .io_rvalid_r(io_rvalid_r));
  // clock generation
  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  task automatic gr_wr(input logic [3:0] idx, input logic [7:0] d);
    u_host.wr(PORT_GR_INDEX, {4'h0, idx});
    u_host.wr(PORT_GR_DATA, d);
  endtask : gr_wr
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_host.rd(a, d, ok);
    check({31'h0, ok}, 32'h1);
    check({24'h0, d}, {24'h0, exp});
  endtask : rd_chk
  task automatic gr_rd(input logic [3:0] idx, input logic [7:0] exp);
    u_host.wr(PORT_GR_INDEX, {4'h0, idx});
    rd_chk(PORT_GR_DATA, exp);
  endtask : gr_rd
  task automatic pos_set(input logic [1:0] lo, input logic [1:0] up);
    u_host.wr(PORT_LOWER_POS, {6'h00, lo});
    u_host.wr(PORT_UPPER_POS, {6'h00, up});
  endtask : pos_set
  task automatic pos_chk(input logic [1:0] lo, input logic [1:0] up);
    u_host.wr(PORT_SEQ_INDEX, SEQ_IDX_LOWER_POS);
    rd_chk(PORT_SEQ_DATA, {6'h00, lo});
    u_host.wr(PORT_SEQ_INDEX, SEQ_IDX_UPPER_POS);
    rd_chk(PORT_SEQ_DATA, {6'h00, up});
  endtask : pos_chk
  task automatic mem_write(input logic [7:0] d, input logic [31:0] exp);
    @(negedge sys_clk);
    mem_wdata_cpu = d;
    mem_wr = 1'b1;
    @(negedge sys_clk);
    mem_wr = 1'b0;
    check({31'h0, mem_we_r}, 32'h1);
    check(mem_wdata_r, exp);
  endtask : mem_write
  task automatic mem_read(input logic [31:0] planes, input logic [7:0] exp);
    @(negedge sys_clk);
    mem_rdata_planes = planes;
    mem_rd = 1'b1;
    @(negedge sys_clk);
    mem_rd = 1'b0;
    check({31'h0, mem_rvalid_r}, 32'h1);
    check({24'h0, mem_rdata_r}, {24'h0, exp});
  endtask : mem_read
  // main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    write_guard_on = 1'b0;
    mem_wr = 1'b0;
    mem_rd = 1'b0;
    mem_wdata_cpu = 8'h00;
    mem_rdata_planes = 32'h0;
    repeat (16) @(negedge sys_clk);
    check({24'h0, io_rdata_r}, 32'h0);
    check(mem_wdata_r, 32'h0);
    rst = 1'b0;
    pos_chk(2'h0, 2'h1);
    // planar writes steered by the two positions, reads fixed on bits 0-3
    foreach (ROWS[i]) begin
      pos_set(ROWS[i].lo, ROWS[i].up);
      pos_chk(ROWS[i].lo, ROWS[i].up);
      gr_wr(ROWS[i].idx, ROWS[i].d);
      gr_rd(ROWS[i].idx, ROWS[i].exp);
    end
    gr_wr(IDX_ROTATE, 8'h1B);
    gr_rd(IDX_ROTATE, 8'h1B);
    // restore after scrambling, with positions left at 1 and 2
    saved = '{8'h0E, 8'h0B, 8'h02, 8'h1B};
    pos_set(2'h3, 2'h0);
    gr_wr(IDX_FILL_VALUE, 8'hFF);
    gr_wr(IDX_ROTATE, 8'h00);
    u_host.restore(2'h1, 2'h2, saved);
    foreach (saved[i]) gr_rd(4'(i), saved[i]);
    pos_chk(2'h1, 2'h2);
    // guarded writes are dropped, index port stays open
    @(negedge sys_clk);
    write_guard_on = 1'b1;
    pos_set(2'h3, 2'h0);
    gr_wr(IDX_FILL_VALUE, 8'h05);
    gr_wr(IDX_ROTATE, 8'h07);
    pos_chk(2'h1, 2'h2);
    gr_rd(IDX_FILL_VALUE, 8'h0E);
    gr_rd(IDX_ROTATE, 8'h1B);
    @(negedge sys_clk);
    write_guard_on = 1'b0;
    // write mode 0 fill on planes 0 and 2, then on all four planes
    pos_set(2'h0, 2'h1);
    gr_wr(IDX_FILL_VALUE, 8'h04);
    gr_wr(IDX_FILL_ENABLE, 8'h05);
    gr_wr(IDX_ROTATE, 8'h00);
    gr_wr(IDX_MODE, 8'h00);
    mem_write(8'hCD, 32'hCDFFCD00);
    gr_wr(IDX_FILL_ENABLE, 8'h0F);
    gr_wr(IDX_FILL_VALUE, 8'h0D);
    mem_write(8'h5A, 32'hFFFF00FF);
    // write mode 2 pin bits follow the positions
    pos_set(2'h2, 2'h3);
    gr_wr(IDX_MODE, 8'h02);
    mem_write(8'hB4, 32'hFF00FFFF);
    // compare read with all four planes compared
    pos_set(2'h0, 2'h1);
    gr_wr(IDX_MATCH_VALUE, 8'h03);
    gr_wr(IDX_IGNORE, 8'h0F);
    gr_wr(IDX_MODE, 8'h08);
    mem_read({8'h00, 8'hFE, 8'h01, 8'hFF}, 8'h01);
    // plain read of plane 2 loads the latches, then latch and masked-fill writes
    gr_wr(IDX_READ_SEL, 8'h02);
    gr_wr(IDX_MODE, 8'h01);
    mem_read({8'h00, 8'hFE, 8'h01, 8'hFF}, 8'hFE);
    mem_write(8'h00, 32'h00FE01FF);
    gr_wr(IDX_MODE, 8'h03);
    mem_write(8'h0F, 32'h0FFF00FF);
    // clock enable low freezes the position registers
    @(negedge sys_clk);
    ce = 1'b0;
    pos_set(2'h3, 2'h2);
    @(negedge sys_clk);
    ce = 1'b1;
    pos_chk(2'h0, 2'h1);
    // reset in mid-run restores the default positions
    pos_set(2'h3, 2'h2);
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    check({24'h0, io_rdata_r}, 32'h0);
    check(mem_wdata_r, 32'h0);
    rst = 1'b0;
    pos_chk(2'h0, 2'h1);
    gr_rd(IDX_FILL_VALUE, 8'h00);
    final_report();
  end
endmodule : planar_bit_group_position_regs_test
`default_nettype wire
